//--- core/cmc_map.vh
// register offsets, field positions, reset values and timing counts of the mode controller
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
`define CMC_OFF_CTRL      12'h000
`define CMC_OFF_FLOOR     12'h004
`define CMC_OFF_CURRENT   12'h008
`define CMC_OFF_CHARGE    12'h00C
`define CMC_OFF_KICK      12'h010
`define CMC_OFF_STATUS    12'h014
`define CMC_OFF_ACTIVE    12'h018
// control register fields
`define CMC_B_ABS_FLOOR   0
`define CMC_B_BOOST_EN    1
`define CMC_B_BOOST_FREQUENCY_SELECT  2
`define CMC_B_PFM_DIS     3
`define CMC_B_OPT_EN      4
`define CMC_B_OPT_FORCE   5
`define CMC_B_RES_LIM_EN  6
`define CMC_B_CHG_EN      7
`define CMC_B_SW_OFF      8
`define CMC_B_SW_RST_EN   9
`define CMC_B_SW_DLY      10
`define CMC_B_IND_DIS     11
`define CMC_B_RECHG_SEL   12
`define CMC_F_TMR_LO      13
`define CMC_F_TMR_HI      14
`define CMC_CTRL_RESET    32'h0000_5250
// charge register reset: charge current code and voltage code
`define CMC_CHG_RESET     16'h2066
`define CMC_CUR_RESET     8'h14
`define CMC_OFS_RESET     8'h06
// clamp current code during soft start (200 mA in 50 mA steps)
`define CMC_SOFT_CLAMP    8'h04
// status field codes
`define CMC_PH_OFF        2'b00
`define CMC_PH_PRE        2'b01
`define CMC_PH_FAST       2'b10
`define CMC_PH_DONE       2'b11
`define CMC_SRC_BOOST     3'b111
// times in their own units and derived cycle counts at 250 MHz
`define CMC_CLK_MHZ       250
`define CMC_BOOST_QUAL_MS 30
`define CMC_BLINK_HZ      1
`define CMC_SAFETY_HOURS  10
`define CMC_BOOST_QUAL_CYC (`CMC_BOOST_QUAL_MS * 1000 * `CMC_CLK_MHZ)
`define CMC_BLINK_HALF_CYC (`CMC_CLK_MHZ * 1000000 / (2 * `CMC_BLINK_HZ))
`define CMC_IRQ_PULSE_CYC 7'h40
// ten hours of clock cycles at 250 MHz
`define CMC_SAFETY_CYC    44'h82F_79CD_9000
`endif

//--- core/cmc_mode_control.v
// charger mode control: floor, start-up, boost, host timer, optimizer, charge cycle, status
//
// Behaviour
// - offset mode computes floor, floor read-only
// - absolute mode lets host write floor
// - interrupt once floor is established
// - switching after current set; battery switch on while charging or converter off
// - clamp current 200 mA below 2.2 V
// - pulse-frequency at light load, low battery, disabled
// - boost only after 30 ms qualified conditions
// - boost reports source 111, needs battery
// - boost frequency write ignored while boost enable bit set
// - boost starts pulse-frequency; disable bit forbids it
// - timeout flag high in default mode
// - reset into default mode, 10-hour limit
// - any host write enters host mode
// - timer expiry resets control and charge registers
// - optimizer runs after charger detect or force
// - active limit from optimizer, resistor clamp
// - charge starts only when all conditions hold
// - charging defaults reloaded at reset
// - terminate on low current, high battery
// - recharge, enable toggle or replug restarts
// - indicator low charging, blink on fault
// - phase codes; interrupt on completion
`timescale 1ns/100ps
`include "cmc_map.vh"
module cmc_mode_control #(
  parameter integer BOOST_QUAL_CYC = `CMC_BOOST_QUAL_CYC,
  parameter integer BLINK_HALF_CYC = `CMC_BLINK_HALF_CYC,
  parameter [43:0]  SAFETY_CYC     = `CMC_SAFETY_CYC,
  parameter integer HOST_TMR_CYC   = 32'd10_000_000
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        input_good,
  input  wire        charger_detected,
  input  wire        dedicated_charger_port,
  input  wire [7:0]  measured_input_voltage,
  input  wire [7:0]  optimizer_result,
  input  wire        optimizer_done,
  input  wire [7:0]  resistor_pin_limit,
  input  wire        system_rail_low,
  input  wire        light_load,
  input  wire        battery_below_min_system,
  input  wire        battery_above_boost_low,
  input  wire        input_below_battery_sleep,
  input  wire        boost_enable_pin,
  input  wire        boost_cold_condition,
  input  wire        boost_hot_condition,
  input  wire        boost_soft_done,
  input  wire        charge_enable_pin_n,
  input  wire        battery_cold_hot,
  input  wire        battery_below_trickle,
  input  wire        charge_current_below_term,
  input  wire        battery_above_recharge,
  input  wire        battery_below_recharge,
  input  wire        in_regulation,
  input  wire        charge_suspend_fault,
  output reg         converter_enable,
  output reg         battery_switch,
  output reg         pulse_frequency_control,
  output reg         boost_active,
  output reg         boost_frequency_select,
  output reg  [7:0]  input_current_ceiling,
  output reg  [7:0]  input_voltage_floor,
  output reg  [2:0]  source_type_status,
  output reg  [1:0]  charge_phase_status,
  output reg         host_timeout,
  output reg         status_pin_n,
  output reg         status_pin_oe,
  output reg         irq_n
);

  // one-word registers
  reg [31:0] ctrl;
  reg [7:0]  floor_reg;
  reg [7:0]  floor_ofs;
  reg [7:0]  prog_current;
  reg [15:0] charge_cfg;
  reg        host_mode;
  reg        floor_set;
  reg        ceiling_set;
  reg        charging;
  reg        charge_done;
  reg        safety_fault;
  reg        opt_run;
  reg [7:0]  opt_limit;
  reg [31:0] qual_cnt;
  reg [31:0] host_cnt;
  reg [43:0] safety_cnt;
  reg [31:0] blink_cnt;
  reg        blink;
  reg [6:0]  irq_cnt;
  reg        prev_enable;
  reg        prev_good;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire known  = (paddr == `CMC_OFF_CTRL) | (paddr == `CMC_OFF_FLOOR) |
                (paddr == `CMC_OFF_CURRENT) | (paddr == `CMC_OFF_CHARGE) |
                (paddr == `CMC_OFF_KICK) | (paddr == `CMC_OFF_STATUS) |
                (paddr == `CMC_OFF_ACTIVE);
  wire [1:0] tmr_sel = ctrl[`CMC_F_TMR_HI:`CMC_F_TMR_LO];
  wire charge_enable = ctrl[`CMC_B_CHG_EN] & ~charge_enable_pin_n;
  wire expired = host_mode & (tmr_sel != 2'b00) & (host_cnt >= HOST_TMR_CYC - 1);

  // smaller of two current codes
  function [7:0] cmc_min;
    input [7:0] a;
    input [7:0] b;
    begin
      cmc_min = (a < b) ? a : b;
    end
  endfunction

  // boost qualification conditions
  wire boost_ok = battery_above_boost_low & input_below_battery_sleep &
                  ctrl[`CMC_B_BOOST_EN] & boost_enable_pin &
                  ~boost_cold_condition & ~boost_hot_condition;
  // charge start conditions
  wire start_ok = converter_enable & charge_enable & (charge_cfg[7:0] != 8'h00) &
                  ~battery_cold_hot & ~safety_fault & ~ctrl[`CMC_B_SW_OFF];
  // completion only when no stop or safety end takes the cycle
  wire done_evt = charging & start_ok & ~(~host_mode & (safety_cnt >= SAFETY_CYC - 1)) &
                  charge_current_below_term & battery_above_recharge & ~in_regulation;
  // optimizer or programmed limit, then resistor clamp
  wire [7:0] base_lim = ctrl[`CMC_B_OPT_EN] ? opt_limit : prog_current;
  wire [7:0] act_lim = ctrl[`CMC_B_RES_LIM_EN] ? cmc_min(base_lim, resistor_pin_limit)
                                               : base_lim;

  // apb slave, zero-wait answer in access phase
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          `CMC_OFF_CTRL:    prdata <= ctrl;
          `CMC_OFF_FLOOR:   prdata <= {16'h0000, floor_ofs, input_voltage_floor};
          `CMC_OFF_CURRENT: prdata <= {24'h00_0000, prog_current};
          `CMC_OFF_CHARGE:  prdata <= {16'h0000, charge_cfg};
          `CMC_OFF_STATUS:  prdata <= {24'h00_0000, host_timeout, source_type_status,
                                       charge_phase_status, safety_fault, charging};
          `CMC_OFF_ACTIVE:  prdata <= {24'h00_0000, act_lim};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire wr_take = wr_acc & pready;

  // register file, host mode and host timer
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl         <= `CMC_CTRL_RESET;
      floor_reg    <= 8'h00;
      floor_ofs    <= `CMC_OFS_RESET;
      prog_current <= `CMC_CUR_RESET;
      charge_cfg   <= `CMC_CHG_RESET;
      host_mode    <= 1'b0;
      host_cnt     <= 32'h0000_0000;
    end
    else if (expired)
    begin
      // keep limits and battery switch bits
      ctrl <= (`CMC_CTRL_RESET & ~32'h0000_0700) | (ctrl & 32'h0000_0700);
      charge_cfg <= `CMC_CHG_RESET;
      host_mode  <= 1'b0;
      host_cnt   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_take)
        host_mode <= 1'b1;
      if (~host_mode | (wr_take & (paddr == `CMC_OFF_KICK) & pwdata[0]))
        host_cnt <= 32'h0000_0000;
      else
        host_cnt <= host_cnt + 32'h0000_0001;
      if (wr_take & (paddr == `CMC_OFF_CTRL))
      begin
        ctrl <= pwdata;
        if (ctrl[`CMC_B_BOOST_EN])
          ctrl[`CMC_B_BOOST_FREQUENCY_SELECT] <= ctrl[`CMC_B_BOOST_FREQUENCY_SELECT];
      end
      if (wr_take & (paddr == `CMC_OFF_FLOOR))
      begin
        floor_ofs <= pwdata[15:8];
        if (ctrl[`CMC_B_ABS_FLOOR])
          floor_reg <= pwdata[7:0];
      end
      if (wr_take & (paddr == `CMC_OFF_CURRENT))
        prog_current <= pwdata[7:0];
      if (wr_take & (paddr == `CMC_OFF_CHARGE))
        charge_cfg <= pwdata[15:0];
    end
  end

  // power-up sequence, soft start and converter mode
  always @(posedge clk)
  begin
    if (rst)
    begin
      floor_set               <= 1'b0;
      ceiling_set             <= 1'b0;
      converter_enable        <= 1'b0;
      battery_switch          <= 1'b0;
      pulse_frequency_control <= 1'b0;
      input_voltage_floor     <= 8'h00;
      input_current_ceiling   <= 8'h00;
      opt_run                 <= 1'b0;
      opt_limit               <= `CMC_CUR_RESET;
      prev_good               <= 1'b0;
    end
    else
    begin
      prev_good <= input_good;
      ceiling_set <= input_good & charger_detected;
      if (~input_good)
        floor_set <= 1'b0;
      else if (ceiling_set)
        floor_set <= 1'b1;
      if (ctrl[`CMC_B_ABS_FLOOR])
        input_voltage_floor <= floor_reg;
      else
        input_voltage_floor <= measured_input_voltage - floor_ofs;
      converter_enable <= input_good & floor_set & ceiling_set;
      battery_switch <= ~(converter_enable & ~charging);
      if (system_rail_low)
        input_current_ceiling <= cmc_min(`CMC_SOFT_CLAMP, act_lim);
      else
        input_current_ceiling <= act_lim;
      // optimizer start and completion
      if ((charger_detected & dedicated_charger_port & ctrl[`CMC_B_OPT_EN] & ~opt_run &
           ~ceiling_set) | ctrl[`CMC_B_OPT_FORCE])
        opt_run <= 1'b1;
      else if (optimizer_done)
        opt_run <= 1'b0;
      if (opt_run & optimizer_done)
        opt_limit <= optimizer_result;
      if (ctrl[`CMC_B_PFM_DIS])
        pulse_frequency_control <= 1'b0;
      else if (boost_active)
        pulse_frequency_control <= ~boost_soft_done;
      else
        pulse_frequency_control <= light_load | battery_below_min_system |
                                   ~charge_enable;
    end
  end

  // boost qualification over the hold time
  always @(posedge clk)
  begin
    if (rst)
    begin
      qual_cnt               <= 32'h0000_0000;
      boost_active           <= 1'b0;
      source_type_status     <= 3'b000;
      boost_frequency_select <= 1'b0;
    end
    else
    begin
      boost_frequency_select <= ctrl[`CMC_B_BOOST_FREQUENCY_SELECT];
      if (~boost_ok)
        qual_cnt <= 32'h0000_0000;
      else if (qual_cnt < BOOST_QUAL_CYC)
        qual_cnt <= qual_cnt + 32'h0000_0001;
      if (boost_active)
        boost_active <= battery_above_boost_low & ctrl[`CMC_B_BOOST_EN] &
                        boost_enable_pin;
      else
        boost_active <= boost_ok & (qual_cnt >= BOOST_QUAL_CYC - 1);
      if (boost_active)
        source_type_status <= `CMC_SRC_BOOST;
      else
        source_type_status <= {2'b00, charger_detected};
    end
  end

  // charge cycle, safety timer and interrupts
  always @(posedge clk)
  begin
    if (rst)
    begin
      charging            <= 1'b0;
      charge_done         <= 1'b0;
      safety_fault        <= 1'b0;
      safety_cnt          <= 44'h000_0000_0000;
      charge_phase_status <= `CMC_PH_OFF;
      prev_enable         <= 1'b0;
      irq_cnt             <= 7'h00;
      irq_n               <= 1'b1;
      host_timeout        <= 1'b1;
    end
    else
    begin
      prev_enable  <= charge_enable;
      host_timeout <= ~host_mode | expired;
      if ((charge_enable & ~prev_enable) | (input_good & ~prev_good))
      begin
        charge_done  <= 1'b0;
        safety_fault <= 1'b0;
        safety_cnt   <= 44'h000_0000_0000;
      end
      else if (charge_done & battery_below_recharge)
        charge_done <= 1'b0;
      if (charging)
      begin
        safety_cnt <= safety_cnt + 44'h000_0000_0001;
        if (~host_mode & (safety_cnt >= SAFETY_CYC - 1))
        begin
          charging     <= 1'b0;
          safety_fault <= 1'b1;
        end
        else if (~start_ok)
          charging <= 1'b0;
        else if (charge_current_below_term & battery_above_recharge & ~in_regulation)
        begin
          charging    <= 1'b0;
          charge_done <= 1'b1;
        end
      end
      else if (start_ok & ~charge_done)
        charging <= 1'b1;
      if (charging)
        charge_phase_status <= battery_below_trickle ? `CMC_PH_PRE : `CMC_PH_FAST;
      else if (charge_done)
        charge_phase_status <= `CMC_PH_DONE;
      else
        charge_phase_status <= `CMC_PH_OFF;
      // merged fixed-length active-low pulse
      if (((floor_set == 1'b0 & input_good & ceiling_set) | done_evt) & (irq_cnt == 7'h00))
        irq_cnt <= `CMC_IRQ_PULSE_CYC;
      else if (irq_cnt != 7'h00)
        irq_cnt <= irq_cnt - 7'h01;
      irq_n <= ~(irq_cnt != 7'h00);
    end
  end

  // status indicator with 1 Hz blink on faults
  always @(posedge clk)
  begin
    if (rst)
    begin
      blink_cnt     <= 32'h0000_0000;
      blink         <= 1'b0;
      status_pin_n  <= 1'b0;
      status_pin_oe <= 1'b0;
    end
    else
    begin
      if (blink_cnt >= BLINK_HALF_CYC - 1)
      begin
        blink_cnt <= 32'h0000_0000;
        blink     <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h0000_0001;
      status_pin_n <= 1'b0;
      if (ctrl[`CMC_B_IND_DIS])
        status_pin_oe <= 1'b0;
      else if (charge_suspend_fault | safety_fault)
        status_pin_oe <= blink;
      else
        status_pin_oe <= charging;
    end
  end

endmodule // cmc_mode_control

//--- dv/cmc_host_model.sv
// host side of the interrupt line: counts active-low pulses
`timescale 1ns/100ps
module cmc_host_model (
  input  wire logic clk,
  input  wire logic irq_n,
  output int        irq_count
);
  logic irq_q = 1'b1;
  initial irq_count = 0;
  // one count per falling edge, however long the pulse
  always @(posedge clk)
  begin
    irq_q <= irq_n;
    if (irq_q && !irq_n)
      irq_count <= irq_count + 1;
  end
endmodule // cmc_host_model

//--- dv/cmc_mode_control_monitor.sv
// concurrent checks on the charger mode controller ports
`timescale 1ns/100ps
module cmc_mode_control_monitor #(
  parameter integer BOOST_QUAL_CYC = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       battery_above_boost_low,
  input wire logic       input_below_battery_sleep,
  input wire logic       boost_enable_pin,
  input wire logic       boost_cold_condition,
  input wire logic       boost_hot_condition,
  input wire logic       system_rail_low,
  input wire logic       charge_suspend_fault,
  input wire logic       boost_active,
  input wire logic       boost_frequency_select,
  input wire logic [7:0] input_current_ceiling,
  input wire logic [2:0] source_type_status,
  input wire logic [1:0] charge_phase_status,
  input wire logic       host_timeout,
  input wire logic       status_pin_oe,
  input wire logic       irq_n
);
  int qual_cnt = 0;
  int low_cnt = 0;
  // run lengths of boost qualification and of interrupt low time
  always @(posedge clk)
  begin
    qual_cnt <= (rst || !(boost_enable_pin && battery_above_boost_low && input_below_battery_sleep
      && !boost_cold_condition && !boost_hot_condition)) ? 0 : qual_cnt + 1;
    low_cnt <= (rst || irq_n) ? 0 : low_cnt + 1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_APB_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_RESET_DEFAULT: assert property ($past(rst) |-> host_timeout)
    else $error("not in default mode after reset");
  AST_WRITE_HOST: assert property (psel && penable && pwrite && pready && !pslverr
    |-> ##2 !host_timeout)
    else $error("write did not enter host mode");
  AST_BOOST_SOURCE: assert property (boost_active [*2] |-> source_type_status == 3'b111)
    else $error("boost without source code 111");
  AST_BOOST_QUAL: assert property ($rose(boost_active) |-> qual_cnt >= BOOST_QUAL_CYC - 2)
    else $error("boost started before qualification time");
  AST_BOOST_DROP: assert property (boost_active && !battery_above_boost_low |-> ##[1:2] !boost_active)
    else $error("boost kept with low battery");
  AST_FREQ_HOLD: assert property (boost_active [*2] |-> $stable(boost_frequency_select))
    else $error("boost frequency changed while boosting");
  AST_IRQ_WIDTH: assert property ($rose(irq_n) |-> low_cnt == 64)
    else $error("interrupt pulse length wrong");
  AST_DONE_IRQ: assert property ($rose(charge_phase_status == 2'b11) |-> ##[0:2] !irq_n)
    else $error("no interrupt on charge done");
  AST_SOFT_CLAMP: assert property (system_rail_low [*2] |-> input_current_ceiling <= 8'h04)
    else $error("ceiling above soft start clamp");
  AST_STAT_HIGH: assert property ((charge_phase_status == 2'b11 && !charge_suspend_fault) [*2]
    |-> !status_pin_oe)
    else $error("status pin pulled low when done");
  // main scenarios reached
  cover property ($rose(boost_active));
  cover property ($fell(irq_n));
  cover property (charge_phase_status == 2'b11);
  cover property (pslverr);
endmodule // cmc_mode_control_monitor

bind cmc_mode_control cmc_mode_control_monitor #(.BOOST_QUAL_CYC(BOOST_QUAL_CYC))
  cmc_mode_control_monitor_inst (.*);

//--- dv/cmc_mode_control_test.sv
// self-checking bench for the charger mode controller
`timescale 1ns/100ps
module cmc_mode_control_test;
  localparam int QC = 20;
  localparam int HT = 100;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr;
  logic [7:0] measured_input_voltage = 0, optimizer_result = 0, resistor_pin_limit = 0, meas;
  logic input_good = 0, charger_detected = 0, dedicated_charger_port = 0, optimizer_done = 0;
  logic system_rail_low = 0, light_load = 0, battery_below_min_system = 0;
  logic battery_above_boost_low = 0, input_below_battery_sleep = 0, boost_enable_pin = 0;
  logic boost_cold_condition = 0, boost_hot_condition = 0, boost_soft_done = 0;
  logic charge_enable_pin_n = 1, battery_cold_hot = 0, battery_below_trickle = 0;
  logic charge_current_below_term = 0, battery_above_recharge = 0, battery_below_recharge = 0;
  logic in_regulation = 0, charge_suspend_fault = 0;
  logic converter_enable, battery_switch, pulse_frequency_control, boost_active;
  logic boost_frequency_select, host_timeout, status_pin_n, status_pin_oe, irq_n;
  logic [7:0] input_current_ceiling, input_voltage_floor;
  logic [2:0] source_type_status;
  logic [1:0] charge_phase_status;
  int num_errors = 0, checks_done = 0, irq_count, seed, n;

  cmc_mode_control #(.BOOST_QUAL_CYC(QC), .BLINK_HALF_CYC(10), .SAFETY_CYC(200),
    .HOST_TMR_CYC(HT)) cmc_mode_control_inst (.*);
  cmc_host_model cmc_host_model_inst (.clk(clk), .irq_n(irq_n), .irq_count(irq_count));

  // 250 MHz clock
  always #2 clk = ~clk;

  function automatic logic [7:0] f_floor(input logic [7:0] v, input logic [7:0] o);
    return v - o;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask

  // one transfer: setup, access until ready, release, two idle cycles
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    @(posedge clk);
  endtask

  task automatic wait_phase(input logic [1:0] p);
    int k = 0;
    while (charge_phase_status !== p && k++ < 600)
      @(posedge clk);
    chk("phase", p, charge_phase_status);
  endtask

  task automatic wait_bit(ref logic s, input logic v, input string nm);
    int k = 0;
    while (s !== v && k++ < 600)
      @(posedge clk);
    chk(nm, v, s);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    seed = 47564;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    meas = 8'h40 + 8'($random(seed) & 63);
    measured_input_voltage <= meas;
    optimizer_result <= 8'($random(seed));
    resistor_pin_limit <= 8'hFF;
    input_good <= 1'b1;
    charger_detected <= 1'b1;
    dedicated_charger_port <= 1'b1;
    optimizer_done <= 1'b1;
    system_rail_low <= 1'b1;
    chk("timeout", 1, host_timeout);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h0000_5250, rd);
    apb(0, 12'h01C, 0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    wait_bit(converter_enable, 1, "conv");
    wt(2);
    chk("switch_off", 0, battery_switch);
    chk("floor", f_floor(meas, 8'h06), input_voltage_floor);
    chk("irq", 1, irq_count > 0);
    chk("clamp", 1, input_current_ceiling <= 8'h04);
    apb(0, 12'h018, 0);
    chk("active", {24'h00_0000, optimizer_result}, rd);
    system_rail_low <= 1'b0;
    done("power_up");
    apb(1, 12'h004, 32'h0000_0633);
    chk("host", 0, host_timeout);
    chk("floor_ro", f_floor(meas, 8'h06), input_voltage_floor);
    apb(1, 12'h000, 32'h0000_5251);
    apb(1, 12'h004, 32'h0000_0633);
    chk("floor_abs", 8'h33, input_voltage_floor);
    apb(1, 12'h008, 32'h0000_000A);
    repeat (3)
    begin
      wt(HT / 4 + ($random(seed) & 15));
      apb(1, 12'h010, 1);
      chk("kicked", 0, host_timeout);
    end
    wt(HT + 20);
    chk("expired", 1, host_timeout);
    apb(0, 12'h000, 0);
    chk("ctrl_reset", 32'h0000_5250, rd);
    apb(0, 12'h008, 0);
    chk("current_kept", 32'h0000_000A, rd);
    done("host_timer");
    input_good <= 1'b0;
    apb(1, 12'h000, 32'h0000_1254);
    chk("freq_set", 1, boost_frequency_select);
    apb(1, 12'h000, 32'h0000_1256);
    battery_above_boost_low <= 1'b1;
    input_below_battery_sleep <= 1'b1;
    boost_enable_pin <= 1'b1;
    wt(QC / 2);
    boost_hot_condition <= 1'b1;
    wt(1);
    boost_hot_condition <= 1'b0;
    wt(QC - 2);
    chk("boost_early", 0, boost_active);
    wait_bit(boost_active, 1, "boost");
    wt(1);
    chk("source", 3'b111, source_type_status);
    chk("pfm_start", 1, pulse_frequency_control);
    apb(1, 12'h000, 32'h0000_1252);
    chk("freq_kept", 1, boost_frequency_select);
    boost_soft_done <= 1'b1;
    wait_bit(pulse_frequency_control, 0, "pfm_off");
    battery_above_boost_low <= 1'b0;
    wt(3);
    chk("boost_drop", 0, boost_active);
    boost_enable_pin <= 1'b0;
    done("boost");
    input_good <= 1'b1;
    charge_enable_pin_n <= 1'b0;
    battery_below_trickle <= 1'b1;
    apb(1, 12'h000, 32'h0000_12D0);
    wait_phase(2'b01);
    chk("stat_low", 1, status_pin_oe);
    chk("switch_on", 1, battery_switch);
    light_load <= 1'b1;
    wt(3);
    chk("pfm_light", 1, pulse_frequency_control);
    apb(1, 12'h000, 32'h0000_12D8);
    chk("pfm_dis", 0, pulse_frequency_control);
    apb(1, 12'h000, 32'h0000_12D0);
    charge_suspend_fault <= 1'b1;
    wait_bit(status_pin_oe, 0, "blink_off");
    wait_bit(status_pin_oe, 1, "blink_on");
    charge_suspend_fault <= 1'b0;
    light_load <= 1'b0;
    battery_below_trickle <= 1'b0;
    wait_phase(2'b10);
    wt(70);
    n = irq_count;
    charge_current_below_term <= 1'b1;
    battery_above_recharge <= 1'b1;
    in_regulation <= 1'b1;
    wt(10);
    chk("no_term", 2'b10, charge_phase_status);
    in_regulation <= 1'b0;
    wait_phase(2'b11);
    wt(3);
    chk("done_irq", n + 1, irq_count);
    chk("stat_high", 0, status_pin_oe);
    charge_current_below_term <= 1'b0;
    battery_above_recharge <= 1'b0;
    battery_below_recharge <= 1'b1;
    wait_phase(2'b10);
    charge_enable_pin_n <= 1'b1;
    wait_phase(2'b00);
    done("charge");
    conclude();
  end

  // cut a hung run short
  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule // cmc_mode_control_test
